// File: dv/ebs_mem_model.sv
// external memory model that answers on the ready pin
`timescale 1ns/1ps
`default_nettype none
module ebs_mem_model
(
    input wire logic i_core_clk,
    input wire ebs_pkg::ebs_pins_t i_pins, // strobes from the block
    input wire logic [15:0] i_data, // data bus from the block
    input wire logic i_stall, // bench asks for a slow device
    output logic o_ready_pin, // ready back to the block
    output logic [15:0] o_wdata // last word written
);
    import ebs_pkg::*;
    // ****************************************
    // slow device handshake
    // ****************************************
    logic [3:0] cnt; // cycles since the access strobe fell
    // a slow device holds ready low for the first cycles of an access
    assign o_ready_pin = !(i_stall && !i_pins.external_access_strobe_n_n && cnt < 4'h8);
    // count strobe cycles and keep the written word
    always @(posedge i_core_clk)
    begin
        cnt <= i_pins.external_access_strobe_n_n ? 4'h0 : cnt + ((cnt < 4'hF) ? 4'h1 : 4'h0);
        if (!i_pins.we_n) o_wdata <= i_data;
    end
endmodule
`default_nettype wire

// File: dv/external_bus_strobe_control_bench.sv
// self-checking bench for the external bus strobe control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module external_bus_strobe_control_bench;
    import ebs_pkg::*;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic clk, rst, vld, rdy, stall, rpin, gin, oe, pco, pcoe, doe, done, ill;
    logic ena, emulator_pin_zero, offn, trst, gsel, gdir, gout, gpin;
    logic [2:0] ws;
    ebs_req_t req;
    ebs_pins_t pins;
    logic [15:0] addr, data, wlast;
    int errors = 0, cmp_count = 0, dcnt = 0, icnt = 0, cyc = 0;
    wire gpin_w = pcoe ? pco : gpin; // shared pin level
    ebs_ctrl i_ebs_ctrl (.i_core_clk(clk), .i_rst(rst), .i_req_valid(vld), .o_req_ready(rdy),
        .i_req(req), .i_wait_state_control(ws), .i_ready_pin(rpin),
        .i_external_interface_enable(ena), .i_emulator_pin_zero(emulator_pin_zero),
        .i_emulation_off_n(offn), .i_test_reset(trst), .i_port_c_bit0_gpio_sel(gsel),
        .i_port_c_bit0_gpio_dir(gdir), .i_port_c_bit0_gpio_out(gout),
        .i_port_c_bit0_pin(gpin_w), .o_port_c_bit0_gpio_in(gin), .o_pins(pins),
        .o_pins_oe(oe), .o_port_c_bit0_o(pco), .o_port_c_bit0_oe(pcoe), .o_addr(addr),
        .o_data(data), .o_data_oe(doe), .o_done(done), .o_illegal_addr(ill));
    ebs_mem_model i_ebs_mem_model (.i_core_clk(clk), .i_pins(pins), .i_data(data),
        .i_stall(stall), .o_ready_pin(rpin), .o_wdata(wlast));
    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // pulse counters and hang limit
    always @(negedge clk)
    begin
        cyc++;
        dcnt += (done === 1'b1);
        icnt += (ill === 1'b1);
        if (cyc == 20000)
        begin
            errors++;
            complete_run();
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic complete_run();
        $display("cmp_count=%0d errors=%0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // hand one request to the fifo, held until taken
    task automatic push(input ebs_space_t sp, input logic wr, input logic [15:0] a);
        int n;
        n = 0;
        @(negedge clk);
        vld = 1'b1;
        req = '{sp, wr, a, ~a};
        while (rdy !== 1'b1 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        @(negedge clk);
        vld = 1'b0;
    endtask
    // one bus cycle, watched until done
    task automatic run_op(input ebs_space_t sp, input logic wr, input logic [2:0] w,
        input logic st);
        ebs_pins_t seen;
        int len, n;
        logic nest, pc;
        logic [15:0] a;
        seen = EBS_PINS_IDLE;
        {len, n, nest, pc} = {32'h0, 32'h0, 1'b1, 1'b0};
        a = {10'h2A5, sp, wr, w};
        ws = w;
        stall = st;
        push(sp, wr, a);
        while (done !== 1'b1 && n < 60)
        begin
            if (pins.external_access_strobe_n_n === 1'b0)
            begin
                len++;
                pc = pc | pco;
                if (pins.rw !== !wr) nest = 1'b0;
                if (!(pins.rd_n & pins.we_n) && (addr !== a || (doe !== wr))) nest = 1'b0;
            end
            else if (pins[6:2] !== 5'h1F) nest = 1'b0;
            seen = seen & pins;
            @(negedge clk);
            n++;
        end
        `CHK(n < 60, 1'b1)
        `CHK(seen[6:4], ~(3'b100 >> sp))
        `CHK(seen.rd_n, wr)
        `CHK(seen.we_n, !wr)
        `CHK(seen.rw, !wr)
        `CHK(pins.rw, 1'b1)
        `CHK(pc, wr)
        `CHK(nest, 1'b1)
        `CHK(len > w + 3, st && w != 0)
        `CHK(len >= w + 3, 1'b1)
        if (wr) `CHK(wlast, ~a)
    endtask
    task automatic t_reset();
        `CHK(pins, EBS_PINS_IDLE)
        `CHK(oe, 1'b1)
        `CHK(pcoe, 1'b0)
        $display("test reset done");
    endtask
    task automatic t_spaces();
        for (int k = 0; k < 6; k++) run_op(ebs_space_t'(k / 2), k[0], k[2:0], 1'b0);
        run_op(EBS_SP_DATA, 1'b1, 3'h7, 1'b0);
        $display("test spaces done");
    endtask
    task automatic t_ready();
        run_op(EBS_SP_IO, 1'b1, 3'h3, 1'b1);
        run_op(EBS_SP_PROG, 1'b0, 3'h0, 1'b1);
        $display("test ready done");
    endtask
    // interface off: data access flagged, others held back
    task automatic t_disable();
        int n, i;
        ws = 3'h0;
        ena = 1'b0;
        repeat (4) @(negedge clk);
        {n, i} = {dcnt, icnt};
        push(EBS_SP_DATA, 1'b0, 16'h0D00);
        push(EBS_SP_PROG, 1'b1, 16'h0E00);
        repeat (12) @(negedge clk);
        `CHK(icnt - i, 1)
        `CHK(dcnt - n, 0)
        `CHK(pins.external_access_strobe_n_n, 1'b1)
        ena = 1'b1;
        repeat (30) @(negedge clk);
        `CHK(dcnt - n, 1)
        $display("test disable done");
    endtask
    // every float pin combination
    task automatic t_float();
        for (int k = 0; k < 8; k++)
        begin
            {offn, trst, emulator_pin_zero} = k[2:0];
            repeat (6) @(negedge clk);
            `CHK(oe, k != 1)
        end
        {offn, trst, emulator_pin_zero} = 3'h5;
        repeat (6) @(negedge clk);
        $display("test float done");
    endtask
    // shared pin in gpio use
    task automatic t_gpio();
        gsel = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            {gdir, gout, gpin} = {k[1], k[0], !k[0]};
            repeat (6) @(negedge clk);
            `CHK(pcoe, k[1])
            `CHK(gin, k[1] ? k[0] : !k[0])
            if (k[1]) `CHK(pco, k[0])
        end
        {gsel, gdir} = 2'h0;
        repeat (4) @(negedge clk);
        $display("test gpio done");
    endtask
    // fill the fifo behind a slow device, then drain it
    task automatic t_fill();
        int acc, n;
        {acc, n} = {32'h0, dcnt};
        {ws, stall} = 4'hF;
        while (rdy === 1'b1 && acc < 20)
        begin
            vld = 1'b1;
            req = '{EBS_SP_IO, acc[0], 16'h1000 + acc[15:0], 16'hF00F};
            @(posedge clk);
            acc++;
            @(negedge clk);
        end
        vld = 1'b0;
        `CHK(rdy, 1'b0)
        `CHK(acc >= EBS_FIFO_DEPTH && acc <= EBS_FIFO_DEPTH + 2, 1'b1)
        stall = 1'b0;
        for (int k = 0; k < 800 && dcnt - n < acc; k++) @(negedge clk);
        `CHK(dcnt - n, acc)
        `CHK(rdy, 1'b1)
        $display("test fill done");
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        rst = 1'b1;
        {vld, stall, trst, gsel, gdir, gout, gpin, ws} = 10'h000;
        {ena, emulator_pin_zero, offn} = 3'h7;
        req = '0;
        repeat (6) @(negedge clk);
        t_reset();
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_spaces();
        t_ready();
        t_disable();
        t_float();
        t_gpio();
        t_fill();
        complete_run();
    end
endmodule
`default_nettype wire

// File: logic/ebs_ctrl.sv
// external bus strobe control top module
`timescale 1ns/1ps
`default_nettype none
module ebs_ctrl #(
    parameter int WS_W = ebs_pkg::EBS_WS_W
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_req_valid, // core request
    output logic o_req_ready,
    input wire ebs_pkg::ebs_req_t i_req,
    input wire logic [WS_W-1:0] i_wait_state_control, // software waits
    input wire logic i_ready_pin, // external ready, async
    input wire logic i_external_interface_enable, // async pin
    input wire logic i_emulator_pin_zero, // async pin
    input wire logic i_emulation_off_n, // async pin
    input wire logic i_test_reset, // async pin
    input wire logic i_port_c_bit0_gpio_sel, // 1 = gpio function
    input wire logic i_port_c_bit0_gpio_dir, // 1 = gpio output
    input wire logic i_port_c_bit0_gpio_out, // gpio output value
    input wire logic i_port_c_bit0_pin, // pin level, async
    output logic o_port_c_bit0_gpio_in, // synchronised pin level
    output ebs_pkg::ebs_pins_t o_pins, // strobe levels
    output logic o_pins_oe, // strobe output enable
    output logic o_port_c_bit0_o, // shared pin drive
    output logic o_port_c_bit0_oe, // shared pin enable
    output logic [ebs_pkg::EBS_ADDR_W-1:0] o_addr,
    output logic [ebs_pkg::EBS_DATA_W-1:0] o_data,
    output logic o_data_oe, // data bus driven
    output logic o_done, // one-cycle completion pulse
    output logic o_illegal_addr // one-cycle illegal access pulse
);
    import ebs_pkg::*;
    // ****************************************
    // input synchronisers
    // ****************************************
    logic [4:0] sync1_q, sync2_q; // ready, ena, emulator_pin_zero, off_n, trst; pc0 has its own pair
    logic pc0_s1_q, pc0_s2_q;
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
            pc0_s1_q <= 1'b0;
            pc0_s2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= {i_ready_pin, i_external_interface_enable, i_emulator_pin_zero,
                i_emulation_off_n, i_test_reset};
            sync2_q <= sync1_q;
            pc0_s1_q <= i_port_c_bit0_pin;
            pc0_s2_q <= pc0_s1_q;
        end
    end
    logic rdy_s, ena_s, emulator_pin_zero_s, off_n_s, trst_s;
    assign {rdy_s, ena_s, emulator_pin_zero_s, off_n_s, trst_s} = sync2_q;
    // ****************************************
    // request fifo
    // ****************************************
    logic f_valid, f_ready;
    ebs_req_t f_req;
    ebs_fifo #(.WIDTH(EBS_REQ_W), .DEPTH(EBS_FIFO_DEPTH)) u_fifo (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_valid(i_req_valid),
        .o_ready(o_req_ready),
        .i_data(i_req),
        .o_valid(f_valid),
        .i_ready(f_ready),
        .o_data(f_req)
    );
    // ****************************************
    // cycle state machine and pin state
    // ****************************************
    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ACTIVE, ST_END} ebs_fsm_t;
    typedef struct packed
    {
        ebs_fsm_t fsm; // cycle phase
        ebs_req_t req; // latched request
        logic [WS_W-1:0] ws; // waits remaining
        logic ws_any; // at least one wait programmed
        ebs_pins_t pins; // strobe levels
        logic pins_oe; // strobes driven
        logic pc0_o; // shared pin level
        logic pc0_oe; // shared pin enable
        logic pc0_in; // gpio input value
        logic data_oe; // data driven
        logic done; // completion pulse
        logic illegal; // illegal access pulse
    } ebs_st_t;
    ebs_st_t st_q, st_d;
    // strobe select for a given space, active low
    function automatic logic [2:0] space_sel_n(input ebs_space_t sp);
        logic [2:0] r;
        r = 3'h7;
        if (sp == EBS_SP_PROG)
        begin
            r[2] = 1'b0;
        end
        else if (sp == EBS_SP_DATA)
        begin
            r[1] = 1'b0;
        end
        else if (sp == EBS_SP_IO)
        begin
            r[0] = 1'b0;
        end
        return r;
    endfunction
    // a data access while the interface is disabled is refused
    logic refuse;
    assign refuse = (st_q.fsm == ST_IDLE) && f_valid && !ena_s && // RULE11
        (f_req.space == EBS_SP_DATA);
    assign f_ready = (st_q.fsm == ST_IDLE) && (ena_s || refuse);
    // next state
    always_comb
    begin
        st_d = st_q;
        st_d.done = 1'b0;
        st_d.illegal = 1'b0;
        st_d.pc0_in = pc0_s2_q;
        case (st_q.fsm)
            ST_IDLE:
            begin
                st_d.pins = EBS_PINS_IDLE; // RULE1 RULE3 RULE8
                st_d.data_oe = 1'b0;
                if (refuse)
                begin
                    st_d.illegal = 1'b1; // RULE11
                end
                else if (f_valid && ena_s)
                begin
                    st_d.req = f_req;
                    st_d.ws = i_wait_state_control;
                    st_d.ws_any = (i_wait_state_control != '0);
                    st_d.pins.external_access_strobe_n_n = 1'b0; // RULE8 RULE12
                    st_d.pins.rw = !f_req.write; // RULE3
                    st_d.fsm = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                // select and enable assert one cycle after strobe
                {st_d.pins.prog_n, st_d.pins.data_n, st_d.pins.io_n} =
                    space_sel_n(st_q.req.space); // RULE1 RULE12
                st_d.pins.rd_n = st_q.req.write; // RULE6
                st_d.pins.we_n = !st_q.req.write; // RULE7
                st_d.data_oe = st_q.req.write; // RULE7
                st_d.fsm = ST_ACTIVE;
            end
            ST_ACTIVE:
            begin
                if (st_q.ws != '0)
                begin
                    st_d.ws = st_q.ws - 1'b1;
                end
                else if (!st_q.ws_any || rdy_s) // RULE10
                begin
                    // release enables and selects before the strobe
                    st_d.pins.rd_n = 1'b1; // RULE12
                    st_d.pins.we_n = 1'b1; // RULE12
                    {st_d.pins.prog_n, st_d.pins.data_n, st_d.pins.io_n} = 3'h7;
                    st_d.fsm = ST_END;
                end
            end
            default:
            begin
                st_d.pins = EBS_PINS_IDLE; // RULE8
                st_d.data_oe = 1'b0;
                st_d.done = 1'b1;
                st_d.fsm = ST_IDLE;
            end
        endcase
        // strobes float only under the emulation off condition
        st_d.pins_oe = !(!off_n_s && !trst_s && emulator_pin_zero_s); // RULE2
        // shared pin: inverted direction qualifier or gpio
        if (i_port_c_bit0_gpio_sel)
        begin
            st_d.pc0_oe = i_port_c_bit0_gpio_dir; // RULE5
            st_d.pc0_o = i_port_c_bit0_gpio_out;
        end
        else
        begin
            st_d.pc0_oe = st_d.pins_oe;
            st_d.pc0_o = !st_d.pins.rw; // RULE4 RULE5
        end
    end
    // state register
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_q <= '0;
            st_q.fsm <= ST_IDLE;
            st_q.pins <= EBS_PINS_IDLE;
            st_q.pins_oe <= 1'b1;
            st_q.pc0_oe <= 1'b0; // RULE9
        end
        else
        begin
            st_q <= st_d;
        end
    end
    assign o_pins = st_q.pins;
    assign o_pins_oe = st_q.pins_oe;
    assign o_port_c_bit0_o = st_q.pc0_o;
    assign o_port_c_bit0_oe = st_q.pc0_oe;
    assign o_port_c_bit0_gpio_in = st_q.pc0_in;
    assign o_addr = st_q.req.addr;
    assign o_data = st_q.req.wdata;
    assign o_data_oe = st_q.data_oe;
    assign o_done = st_q.done;
    assign o_illegal_addr = st_q.illegal;
    // ****************************************
    // checks
    // ****************************************
    // at most one space select low at a time
    one_space_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE1
        $countones({o_pins.prog_n, o_pins.data_n, o_pins.io_n}) >= 2)
        else $error("more than one space select low");
    // an io cycle selects only the io space
    io_sel_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE1
        (st_q.fsm == ST_SETUP && st_q.req.space == EBS_SP_IO)
        |=> !o_pins.io_n && o_pins.prog_n && o_pins.data_n)
        else $error("io cycle selected wrong space");
    // float condition releases the strobes
    float_cond_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE2
        (!off_n_s && !trst_s && emulator_pin_zero_s) |=> !o_pins_oe)
        else $error("strobes driven under emulation off");
    // outside the float condition the strobes are driven
    float_off_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE2
        !(!off_n_s && !trst_s && emulator_pin_zero_s) |=> o_pins_oe)
        else $error("strobes floating without emulation off");
    // write enable never comes with direction high
    dir_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE3
        !(!o_pins.we_n && o_pins.rw))
        else $error("direction high during write enable");
    // direction follows the request from the first strobe cycle
    dir_setup_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE3
        (st_q.fsm == ST_SETUP) |-> (o_pins.rw == !st_q.req.write))
        else $error("direction wrong in setup");
    // inverted qualifier tracks the direction in bus mode
    inv_dir_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE4
        !i_port_c_bit0_gpio_sel && !$past(i_port_c_bit0_gpio_sel)
        |-> o_port_c_bit0_o == !o_pins.rw)
        else $error("inverted qualifier mismatch");
    // inverted qualifier rests low between cycles
    inv_idle_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE4
        (!$past(i_port_c_bit0_gpio_sel) && st_q.fsm == ST_IDLE) |-> !o_port_c_bit0_o)
        else $error("inverted qualifier high while idle");
    // gpio use drives the shared pin as configured
    gpio_dir_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE5
        (!$past(i_rst) && $past(i_port_c_bit0_gpio_sel))
        |-> o_port_c_bit0_oe == $past(i_port_c_bit0_gpio_dir))
        else $error("gpio direction not applied");
    // read enable follows a read setup phase
    rd_en_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE6
        (st_q.fsm == ST_SETUP && !st_q.req.write) |=> !o_pins.rd_n)
        else $error("read enable missing");
    // a read never drives the data bus
    rd_drive_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE6
        !o_pins.rd_n |-> !o_data_oe)
        else $error("data driven during read");
    // write enable follows a write setup phase
    we_en_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE7
        (st_q.fsm == ST_SETUP && st_q.req.write) |=> !o_pins.we_n && o_data_oe)
        else $error("write enable missing");
    // the write enable comes with the data bus driven
    we_drive_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE7
        !o_pins.we_n |-> o_data_oe)
        else $error("write enable without data drive");
    // the strobe falls right after a request is taken
    external_access_strobe_n_cycle_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE8
        (f_valid && f_ready && ena_s) |=> !o_pins.external_access_strobe_n_n [*2])
        else $error("access strobe not low in cycle");
    // idle phase shows every strobe at rest
    idle_pins_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE8
        (st_q.fsm == ST_IDLE) |-> (o_pins == EBS_PINS_IDLE))
        else $error("strobes active while idle");
    // the end phase releases the strobe and pulses done
    done_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE8
        (st_q.fsm == ST_END) |=> o_done && o_pins.external_access_strobe_n_n)
        else $error("cycle end not signalled");
    // shared pin is an input just after reset
    oe_reset_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE9
        $past(i_rst) |-> !o_port_c_bit0_oe)
        else $error("shared pin driven after reset");
    // programmed waits hold the active phase
    ws_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE10
        (st_q.fsm == ST_ACTIVE && st_q.ws != '0) |=> (st_q.fsm == ST_ACTIVE))
        else $error("wait state skipped");
    // ready low stalls the cycle when waits are programmed
    rdy_stall_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE10
        (st_q.fsm == ST_ACTIVE && st_q.ws == '0 && st_q.ws_any && !rdy_s)
        |=> (st_q.fsm == ST_ACTIVE))
        else $error("ready stall ignored");
    // with no waits programmed ready is not consulted
    rdy_ignore_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE10
        (st_q.fsm == ST_ACTIVE && !st_q.ws_any) |=> (st_q.fsm == ST_END))
        else $error("cycle stalled without waits");
    // a refused data access is flagged and never selected
    illegal_ds_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE11
        refuse |=> o_illegal_addr && o_pins.data_n)
        else $error("illegal data access not flagged");
    // a disabled interface starts no bus cycle
    no_ext_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE11
        (st_q.fsm == ST_IDLE && !ena_s) |=> o_pins.external_access_strobe_n_n)
        else $error("bus cycle with interface disabled");
    // enables and the data select only inside the strobe
    nest_external_access_strobe_n_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE12
        (!o_pins.rd_n || !o_pins.we_n || !o_pins.data_n) |-> !o_pins.external_access_strobe_n_n)
        else $error("enable outside access strobe");
    // end phase keeps the strobe with enables released
    end_phase_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE12
        (st_q.fsm == ST_END) |-> o_pins.rd_n && o_pins.we_n && !o_pins.external_access_strobe_n_n)
        else $error("end phase strobes wrong");
endmodule
`default_nettype wire

// File: logic/ebs_fifo.sv
// request fifo for the external bus strobe control block
`timescale 1ns/1ps
`default_nettype none
module ebs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    // ****************************************
    // storage and pointers
    // ****************************************
    logic [WIDTH-1:0] mem [DEPTH]; // word array
    typedef struct packed
    {
        logic [AW-1:0] wp; // write pointer
        logic [AW-1:0] rp; // read pointer
        logic [AW:0] cnt; // occupancy
    } ebs_fifo_st_t;
    ebs_fifo_st_t st_q, st_d;
    logic push, pop;
    assign o_ready = (st_q.cnt != (AW+1)'(DEPTH));
    assign o_valid = (st_q.cnt != '0);
    assign o_data = mem[st_q.rp];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    // next pointer state
    always_comb
    begin
        st_d = st_q;
        if (push)
        begin
            st_d.wp = (st_q.wp == AW'(DEPTH-1)) ? '0 : st_q.wp + 1'b1;
        end
        if (pop)
        begin
            st_d.rp = (st_q.rp == AW'(DEPTH-1)) ? '0 : st_q.rp + 1'b1;
        end
        st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    // state register
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end
    // data write, no reset needed
    always_ff @(posedge i_core_clk)
    begin
        if (push)
        begin
            mem[st_q.wp] <= i_data;
        end
    end
endmodule
`default_nettype wire

// File: logic/ebs_pkg.sv
// package for the external bus strobe control block
// Contract
// RULE1: space strobe low only for accessed space
// RULE2: strobes float only under emulation off condition
// RULE3: direction qualifier high except during writes
// RULE4: inverted direction qualifier high only during writes
// RULE5: inverted qualifier shares pin with gpio
// RULE6: read enable low on every external read
// RULE7: write enable low on every external write
// RULE8: access strobe low for every off-chip cycle
// RULE9: gpio pins come out of reset as inputs
// RULE10: ready low adds waits if waits programmed
// RULE11: interface disabled flags illegal data access
// RULE12: enables and space strobe nest inside access strobe
`default_nettype none
package ebs_pkg;
    // ****************************************
    // address spaces and request carrier
    // ****************************************
    typedef enum logic [1:0] {EBS_SP_PROG, EBS_SP_DATA, EBS_SP_IO} ebs_space_t;
    localparam int EBS_ADDR_W = 16; // external address width
    localparam int EBS_DATA_W = 16; // external data width
    localparam int EBS_WS_W = 3; // wait state count width
    localparam int EBS_FIFO_DEPTH = 8; // request fifo depth
    typedef struct packed
    {
        ebs_space_t space; // target space
        logic write; // 1 = write, 0 = read
        logic [EBS_ADDR_W-1:0] addr; // address
        logic [EBS_DATA_W-1:0] wdata; // write data
    } ebs_req_t;
    localparam int EBS_REQ_W = $bits(ebs_req_t); // fifo word width
    // pin level bundle, all strobes active low except direction
    typedef struct packed
    {
        logic prog_n; // program space select
        logic data_n; // data space select
        logic io_n; // io space select
        logic rd_n; // read enable
        logic we_n; // write enable
        logic external_access_strobe_n_n; // access strobe
        logic rw; // direction qualifier
    } ebs_pins_t;
    localparam ebs_pins_t EBS_PINS_IDLE = 7'h7F; // all idle, direction read
endpackage
`default_nettype wire
